// file: verilog/pwit_pkg.sv
`default_nettype none
package pwit_pkg;
	localparam logic [15:0] CSR_READ_ADDR = 16'hFFEC;
	localparam logic [15:0] CNT_READ_ADDR = 16'hFFED;
	localparam logic [15:0] WRITE_ADDR = 16'hFFEC;
	localparam logic [7:0] CNT_PASSWORD = 8'h5A;
	localparam logic [7:0] CSR_PASSWORD = 8'hA5;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CSR_RESET = 8'h18;
	localparam int OVF_BIT = 7;
	localparam int MODE_BIT = 6;
	localparam int RUN_BIT = 5;
	localparam int CKS_LSB = 0;
	localparam int CKS_WIDTH = 3;
	localparam int PRESCALE_WIDTH = 12;
	localparam logic [2:0] CKS_RESET = 3'h0;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	typedef struct packed {
		logic rd;
		logic wr;
		logic word;
		logic [15:0] addr;
		logic [15:0] wdata;
	} pwit_bus_req_t;

	typedef struct packed {
		logic ovf;
		logic mode;
		logic run;
		logic [CKS_WIDTH-1:0] cks;
	} pwit_csr_t;
endpackage : pwit_pkg
`default_nettype wire

// file: verilog/pwit_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - count prescaled pulses while run enabled
// - wrap FF to 00 sets overflow flag
// - counter zero at reset, held at zero when disabled
// - bits 7..5 cleared by reset and standby
// - divider select cleared only by reset
// - overflow cleared by reset, standby, or read-1-then-write-0
// - mode bit picks line-zero or nonmaskable request
// - running count requests interrupt each overflow
// - interval mode requests once per cycle
// - divider select decodes to eight ratios
// - bits 4 and 3 read one
// - byte writes ignored
// - shared write address, high byte password
// - byte reads at FFEC status, FFED count
// - request raised with overflow flag
// - bus write beats coincident increment
// - standby wake counts, releases clocks, no flag
// - standby refused while run enabled
module pwit_timer (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire pwit_pkg::pwit_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	input wire logic standby_enter,
	input wire logic soft_standby_req,
	output logic soft_standby_grant,
	input wire logic standby_wake_nmi,
	output logic clock_release,
	output logic nmi_req,
	output logic external_line_zero_interrupt
);
	logic [pwit_pkg::PRESCALE_WIDTH-1:0] prescale_reg;
	logic [7:0] wd_counter_reg;
	pwit_pkg::pwit_csr_t csr_reg;
	logic ovf_armed_reg;
	logic recovering_reg;
	logic tick;
	logic cnt_write;
	logic csr_write;
	logic csr_read;
	logic wrap;
	logic run_next;
	logic [7:0] csr_view;

	function automatic logic [pwit_pkg::PRESCALE_WIDTH-1:0] ratio_mask(input logic [2:0] sel);
		case (sel)
			3'h0: ratio_mask = 12'h001;
			3'h1: ratio_mask = 12'h01F;
			3'h2: ratio_mask = 12'h03F;
			3'h3: ratio_mask = 12'h07F;
			3'h4: ratio_mask = 12'h0FF;
			3'h5: ratio_mask = 12'h1FF;
			3'h6: ratio_mask = 12'h7FF;
			default: ratio_mask = 12'hFFF;
		endcase
	endfunction : ratio_mask

	// prescaler runs free; a tick is the carry out of the selected stage
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			prescale_reg <= '0;
		end else begin
			prescale_reg <= prescale_reg + 12'h001;
		end
	end

	assign tick = (prescale_reg & ratio_mask(csr_reg.cks)) == ratio_mask(csr_reg.cks);

	// word write at the even address covering both byte slots
	always_comb begin
		cnt_write = 1'b0;
		csr_write = 1'b0;
		if (bus_req.wr && bus_req.word && bus_req.addr[15:1] == pwit_pkg::WRITE_ADDR[15:1]) begin
			if (bus_req.wdata[15:8] == pwit_pkg::CNT_PASSWORD) begin
				cnt_write = 1'b1;
			end else if (bus_req.wdata[15:8] == pwit_pkg::CSR_PASSWORD) begin
				csr_write = 1'b1;
			end
			// any other high byte leaves both registers alone
		end
	end

	assign csr_read = bus_req.rd && bus_req.addr == pwit_pkg::CSR_READ_ADDR;
	assign run_next = standby_enter ? 1'b0 : (csr_write ? bus_req.wdata[pwit_pkg::RUN_BIT] : csr_reg.run);
	assign wrap = tick && !cnt_write && wd_counter_reg == pwit_pkg::CNT_MAX
		&& (csr_reg.run || recovering_reg);
	assign csr_view = {csr_reg.ovf, csr_reg.mode, csr_reg.run, 2'b11, csr_reg.cks};

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wd_counter_reg <= pwit_pkg::CNT_RESET;
		end else if (standby_enter && !standby_wake_nmi) begin
			wd_counter_reg <= pwit_pkg::CNT_RESET;
		end else if (!run_next && !recovering_reg && !standby_wake_nmi) begin
			wd_counter_reg <= pwit_pkg::CNT_RESET;
		end else if (cnt_write) begin
			wd_counter_reg <= bus_req.wdata[7:0];
		end else if (tick) begin
			wd_counter_reg <= wd_counter_reg + 8'h01;
		end
	end

	// standby wake counts with run bit still clear; overflow only frees clocks
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			recovering_reg <= 1'b0;
			clock_release <= 1'b0;
		end else begin
			clock_release <= recovering_reg && !csr_reg.run && wrap;
			if (standby_wake_nmi) begin
				recovering_reg <= 1'b1;
			end else if (wrap) begin
				recovering_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			csr_reg.mode <= 1'b0;
			csr_reg.run <= 1'b0;
		end else if (standby_enter) begin
			csr_reg.mode <= 1'b0;
			csr_reg.run <= 1'b0;
		end else if (csr_write) begin
			csr_reg.mode <= bus_req.wdata[pwit_pkg::MODE_BIT];
			csr_reg.run <= bus_req.wdata[pwit_pkg::RUN_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			csr_reg.cks <= pwit_pkg::CKS_RESET;
		end else if (csr_write) begin
			csr_reg.cks <= bus_req.wdata[pwit_pkg::CKS_LSB +: pwit_pkg::CKS_WIDTH];
		end
	end

	// set wins over clear; a clear needs a prior read that saw the flag high
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			csr_reg.ovf <= 1'b0;
			ovf_armed_reg <= 1'b0;
		end else if (wrap && csr_reg.run) begin
			csr_reg.ovf <= 1'b1;
			ovf_armed_reg <= 1'b0;
		end else if (standby_enter) begin
			csr_reg.ovf <= 1'b0;
			ovf_armed_reg <= 1'b0;
		end else if (csr_write && ovf_armed_reg && !bus_req.wdata[pwit_pkg::OVF_BIT]) begin
			csr_reg.ovf <= 1'b0;
			ovf_armed_reg <= 1'b0;
		end else if (csr_read && csr_reg.ovf) begin
			ovf_armed_reg <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			nmi_req <= 1'b0;
			external_line_zero_interrupt <= 1'b0;
		end else begin
			nmi_req <= wrap && csr_reg.run && csr_reg.mode;
			external_line_zero_interrupt <= wrap && csr_reg.run && !csr_reg.mode;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_rdata <= pwit_pkg::RDATA_RESET;
		end else if (bus_req.rd) begin
			if (bus_req.addr == pwit_pkg::CSR_READ_ADDR) begin
				bus_rdata <= csr_view;
			end else if (bus_req.addr == pwit_pkg::CNT_READ_ADDR) begin
				bus_rdata <= wd_counter_reg;
			end else begin
				bus_rdata <= pwit_pkg::RDATA_RESET;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			soft_standby_grant <= 1'b0;
		end else begin
			soft_standby_grant <= soft_standby_req && !csr_reg.run && !run_next;
		end
	end
endmodule : pwit_timer
`default_nettype wire

// file: verilog/pwit_dummy_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: test/pwit_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pwit_timer_chk (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire pwit_pkg::pwit_bus_req_t bus_req,
	input wire logic [7:0] bus_rdata,
	input wire logic soft_standby_req,
	input wire logic soft_standby_grant,
	input wire logic clock_release,
	input wire logic nmi_req,
	input wire logic external_line_zero_interrupt
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	property p_excl; !(nmi_req && external_line_zero_interrupt); endproperty
	a_excl: assert property (p_excl) else $error("both requests high");
	property p_nmi; nmi_req |=> !nmi_req; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi request too long");
	property p_irq; external_line_zero_interrupt |=> !external_line_zero_interrupt; endproperty
	a_irq: assert property (p_irq) else $error("line request too long");
	property p_rel; clock_release |=> !clock_release; endproperty
	a_rel: assert property (p_rel) else $error("release too long");
	property p_gnt; soft_standby_grant |-> $past(soft_standby_req); endproperty
	a_gnt: assert property (p_gnt) else $error("grant without request");
	property p_res; bus_req.rd && bus_req.addr == 16'hFFEC |=> bus_rdata[4:3] == 2'h3; endproperty
	a_res: assert property (p_res) else $error("reserved bits not one");
	property p_hold; !bus_req.rd |=> $stable(bus_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	// the idle cycle between write and read is the cpu model's spacing
	property p_wr; bus_req.wr && bus_req.word && bus_req.addr[15:1] == 15'h7FF6 && bus_req.wdata[15:8] == 8'hA5
		##2 bus_req.rd && bus_req.addr == 16'hFFEC |=> bus_rdata[6:0] == ($past(bus_req.wdata[6:0], 3) | 7'h18); endproperty
	a_wr: assert property (p_wr) else $error("status write lost");
	c_nmi: cover property (nmi_req);
	c_irq: cover property (external_line_zero_interrupt);
	c_rel: cover property (clock_release);
endmodule : pwit_timer_chk
bind pwit_timer pwit_timer_chk chk_u (.ref_clk(ref_clk), .arst_n(arst_n), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .soft_standby_req(soft_standby_req), .soft_standby_grant(soft_standby_grant),
	.clock_release(clock_release), .nmi_req(nmi_req), .external_line_zero_interrupt(external_line_zero_interrupt));
`default_nettype wire

// file: test/pwit_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwit_cpu_model (
	input wire logic ref_clk,
	output var pwit_pkg::pwit_bus_req_t bus_req,
	input wire logic [7:0] bus_rdata
);
	initial bus_req = '0;
	// password in the high byte, data low, one shared address
	task automatic wr(input logic w, input logic [15:0] d);
		@(posedge ref_clk);
		bus_req <= '{1'b0, 1'b1, w, pwit_pkg::WRITE_ADDR, d};
		@(posedge ref_clk);
		bus_req <= '0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] q);
		@(posedge ref_clk);
		bus_req <= '{1'b1, 1'b0, 1'b0, a, 16'h0000};
		@(posedge ref_clk);
		bus_req <= '0;
		@(negedge ref_clk);
		q = bus_rdata;
	endtask : rd
endmodule : pwit_cpu_model
`default_nettype wire

// file: test/pwit_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pwit_timer_tb;
	logic ref_clk = 0, arst_n = 0, sb_in = 0, sb_req = 0, wake = 0, gnt, rel, nmi, irq;
	logic [7:0] q, q2, rdata;
	logic [2:0] ev;
	pwit_pkg::pwit_bus_req_t bus_req;
	int mismatches = 0, n_compared = 0, i;
	int divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
	assign ev = {rel, nmi, irq};
	always #4 ref_clk = ~ref_clk;
	pwit_cpu_model cpu_u (.ref_clk(ref_clk), .bus_req(bus_req), .bus_rdata(rdata));
	pwit_timer dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(rdata),
		.standby_enter(sb_in), .soft_standby_req(sb_req), .soft_standby_grant(gnt), .standby_wake_nmi(wake),
		.clock_release(rel), .nmi_req(nmi), .external_line_zero_interrupt(irq));
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
		cpu_u.rd(a, q);
		chk(a[0] ? "counter" : "status", {8'h00, q}, {8'h00, e});
	endtask : rchk
	// negedge sampling keeps one-cycle pulses clear of the launching edge
	task automatic upto(input int n, input int w);
		for (i = 0; i < n && ev[w] !== 1'b1; i++) @(negedge ref_clk);
	endtask : upto
	task automatic test_done();
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	initial begin
		repeat (12) @(posedge ref_clk);
		arst_n <= 1;
		rchk(16'hFFEC, 8'h18);
		rchk(16'hFFED, 8'h00);
		cpu_u.wr(1, 16'h5A33);
		rchk(16'hFFED, 8'h00);
		cpu_u.wr(1, 16'hA5A7);
		rchk(16'hFFEC, 8'h3F);
		cpu_u.wr(1, 16'h5A40);
		rchk(16'hFFED, 8'h40);
		cpu_u.wr(0, 16'h5A77);
		rchk(16'hFFED, 8'h40);
		cpu_u.wr(1, 16'h3C11);
		rchk(16'hFFED, 8'h40);
		rchk(16'hFFEC, 8'h3F);
		foreach (divs[k]) begin
			cpu_u.wr(1, {8'hA5, 5'h00, 3'(k)});
			rchk(16'hFFED, 8'h00);
			cpu_u.wr(1, {8'hA5, 5'h04, 3'(k)});
			// window of exactly 4*ratio edges holds four ticks whatever the prescaler phase
			repeat (4 * divs[k] - 2) @(posedge ref_clk);
			rchk(16'hFFED, 8'h04);
		end
		cpu_u.wr(1, 16'hA520);
		upto(600, 0);
		chk("irq", irq, 1'b1);
		chk("nmi", nmi, 1'b0);
		@(negedge ref_clk);
		upto(600, 0);
		chk("period", i, 16'h01FF);
		// two writes of opposite tick parity: one meets a tick, so the pair reads 40 and 41
		cpu_u.wr(1, 16'h5A40);
		cpu_u.rd(16'hFFED, q2);
		@(posedge ref_clk);
		cpu_u.wr(1, 16'h5A40);
		cpu_u.rd(16'hFFED, q);
		chk("race", {8'h00, q} + {8'h00, q2}, 16'h0081);
		rchk(16'hFFEC, 8'hB8);
		cpu_u.wr(1, 16'h5A00);
		cpu_u.wr(1, 16'hA560);
		rchk(16'hFFEC, 8'h78);
		upto(600, 1);
		chk("nmi", nmi, 1'b1);
		chk("irq", irq, 1'b0);
		cpu_u.wr(1, 16'hA521);
		sb_req <= 1;
		repeat (3) @(negedge ref_clk);
		chk("grant", gnt, 1'b0);
		@(posedge ref_clk) sb_in <= 1;
		@(posedge ref_clk) sb_in <= 0;
		rchk(16'hFFEC, 8'h19);
		chk("grant", gnt, 1'b1);
		@(posedge ref_clk) wake <= 1;
		@(posedge ref_clk) wake <= 0;
		upto(8400, 2);
		chk("release", rel, 1'b1);
		rchk(16'hFFEC, 8'h19);
		test_done();
	end
	initial begin
		#600000;
		mismatches++;
		test_done();
	end
endmodule : pwit_timer_tb
`default_nettype wire
